/* hdl/gpc_consts.svh */
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
// register indices; byte address is four times the index
`define GPC_IDX_PIN_FUNC 6'h17
`define GPC_IDX_DUTY_ONE 6'h18
`define GPC_IDX_DUTY_TWO 6'h19
`define GPC_IDX_FREQ 6'h1C
`define GPC_IDX_SCRATCH 6'h1E
`define GPC_RST_VAL 8'h00
// field positions
`define GPC_FPD_MSB 7
`define GPC_FPD_LSB 6
`define GPC_P2_MSB 5
`define GPC_P2_LSB 3
`define GPC_P1_MSB 2
`define GPC_P1_LSB 0
`define GPC_FREQ1_BIT 0
`define GPC_FREQ2_BIT 2
`define GPC_FREQ_MASK 8'h05
// pin function codes
`define GPC_CODE_OFF 3'h4
`define GPC_CODE_WAKE 3'h5
`define GPC_CODE_LS 3'h6
`define GPC_CODE_HS 3'h7
// switch selector codes
`define GPC_HS_PWM1 3'h4
`define GPC_HS_PWM2 3'h5
// fail pulse duty in per mille
`define GPC_FPD_20 8'hC8
`define GPC_FPD_10 8'h64
`define GPC_FPD_5 8'h32
`define GPC_FPD_2P5 8'h19
// pwm
`define GPC_DUTY_FULL 8'hFF
`define GPC_PWM_STEPS 255
`define GPC_PWM_LAST 8'hFE
`define GPC_CLK_HZ 50000000
`define GPC_F_LOW_HZ 200
`define GPC_F_HIGH_HZ 400
`define GPC_STEP_LOW_CYC (`GPC_CLK_HZ / (`GPC_F_LOW_HZ * `GPC_PWM_STEPS))
`define GPC_STEP_HIGH_CYC (`GPC_CLK_HZ / (`GPC_F_HIGH_HZ * `GPC_PWM_STEPS))
// wake filter, least time rounded up
`define GPC_WAKE_FILT_NS 16000
`define GPC_WAKE_FILT_CYC ((`GPC_WAKE_FILT_NS * (`GPC_CLK_HZ / 1000000) + 999) / 1000)
`endif

/* hdl/gpc_pkg.sv */
`default_nettype none
package gpc_pkg;
    typedef enum logic [2:0] {
        GPC_MODE_FAIL,
        GPC_MODE_OFF,
        GPC_MODE_WAKE,
        GPC_MODE_LS,
        GPC_MODE_HS
    } gpc_pin_mode_t;
    typedef struct packed {
        logic fail_out;
        logic wake_en;
        logic wake_level;
        logic low_side_on;
        logic high_side_on;
    } gpc_pin_ctrl_t;
    typedef logic [3:0][2:0] gpc_hs_sel_t;
endpackage : gpc_pkg
`default_nettype wire

/* hdl/gpc_top.sv */
`include "gpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// pwm generator
module gpc_pwm_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] duty,
    input wire logic fast,
    output logic pwm_out
);
    import gpc_pkg::*;
    logic [9:0] pre_r;
    logic [9:0] pre_nxt;
    logic [7:0] step_r;
    logic [7:0] step_nxt;
    logic out_r;
    logic out_nxt;
    logic [9:0] step_len;
    always_comb begin
        step_len = fast ? 10'(`GPC_STEP_HIGH_CYC) : 10'(`GPC_STEP_LOW_CYC);
        pre_nxt = pre_r + 10'h001;
        step_nxt = step_r;
        if (pre_r >= step_len - 10'h001) begin
            pre_nxt = 10'h000;
            step_nxt = (step_r >= `GPC_PWM_LAST) ? 8'h00 : step_r + 8'h01;
        end
        // on for duty steps from period start
        out_nxt = (duty == `GPC_DUTY_FULL) || (step_r < duty);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 10'h000;
            step_r <= 8'h00;
            out_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            step_r <= step_nxt;
            out_r <= out_nxt;
        end
    end
    assign pwm_out = out_r;
endmodule : gpc_pwm_gen

// =====================================================
// static wake filter
module gpc_wake_filt (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic pin_in,
    output logic level
);
    import gpc_pkg::*;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic lvl_r;
    logic lvl_nxt;
    always_comb begin
        cnt_nxt = 10'h000;
        lvl_nxt = lvl_r;
        if (!en) begin
            lvl_nxt = 1'b0;
        end else if (pin_in != lvl_r) begin
            // level must hold stable for the whole filter time
            if (cnt_r >= 10'(`GPC_WAKE_FILT_CYC) - 10'h001) begin
                lvl_nxt = pin_in;
            end else begin
                cnt_nxt = cnt_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 10'h000;
            lvl_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            lvl_r <= lvl_nxt;
        end
    end
    assign level = lvl_r;
endmodule : gpc_wake_filt

// =====================================================
// top
module gpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic soft_reset_req,
    input wire logic normal_mode,
    input wire logic pin_one_in,
    input wire logic pin_two_in,
    input wire gpc_pkg::gpc_hs_sel_t hs_sel,
    output gpc_pkg::gpc_pin_ctrl_t pin_one_ctrl,
    output gpc_pkg::gpc_pin_ctrl_t pin_two_ctrl,
    output logic [1:0] fail_pulse_duty,
    output logic [7:0] fail_duty_permille,
    output logic pwm_first_out,
    output logic pwm_second_out,
    output logic [3:0] hs_pwm_ctrl,
    output logic [3:0] hs_pwm_level
);
    import gpc_pkg::*;
    // =====================================================
    // decode helpers
    function automatic gpc_pin_mode_t pin_mode(input logic [2:0] code);
        gpc_pin_mode_t m;
        m = GPC_MODE_FAIL;
        unique case (code)
            `GPC_CODE_OFF: m = GPC_MODE_OFF;
            `GPC_CODE_WAKE: m = GPC_MODE_WAKE;
            `GPC_CODE_LS: m = GPC_MODE_LS;
            `GPC_CODE_HS: m = GPC_MODE_HS;
            default: m = GPC_MODE_FAIL;
        endcase
        return m;
    endfunction : pin_mode
    function automatic gpc_pin_ctrl_t pin_ctrl(input gpc_pin_mode_t m, input logic wl);
        gpc_pin_ctrl_t c;
        c = '0;
        c.fail_out = (m == GPC_MODE_FAIL);
        c.wake_en = (m == GPC_MODE_WAKE);
        c.wake_level = (m == GPC_MODE_WAKE) && wl;
        c.low_side_on = (m == GPC_MODE_LS);
        c.high_side_on = (m == GPC_MODE_HS);
        return c;
    endfunction : pin_ctrl
    // =====================================================
    // apb decode
    logic setup_ph;
    logic wr_en;
    logic aligned;
    logic [5:0] idx;
    logic hit_pin;
    logic hit_d1;
    logic hit_d2;
    logic hit_frq;
    logic hit_scr;
    logic mapped;
    logic lane0;
    assign setup_ph = psel && !penable;
    assign aligned = (paddr[1:0] == 2'b00);
    assign idx = paddr[7:2];
    assign hit_pin = aligned && (idx == `GPC_IDX_PIN_FUNC);
    assign hit_d1 = aligned && (idx == `GPC_IDX_DUTY_ONE);
    assign hit_d2 = aligned && (idx == `GPC_IDX_DUTY_TWO);
    assign hit_frq = aligned && (idx == `GPC_IDX_FREQ);
    assign hit_scr = aligned && (idx == `GPC_IDX_SCRATCH);
    assign mapped = hit_pin || hit_d1 || hit_d2 || hit_frq || hit_scr;
    assign lane0 = pstrb[0];
    assign wr_en = psel && penable && pwrite && mapped && lane0;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // =====================================================
    // configuration registers
    logic [7:0] pin_func_r;
    logic [7:0] pin_func_nxt;
    logic [7:0] duty_one_r;
    logic [7:0] duty_one_nxt;
    logic [7:0] duty_two_r;
    logic [7:0] duty_two_nxt;
    logic [7:0] freq_r;
    logic [7:0] freq_nxt;
    logic [7:0] scratch_r;
    logic [7:0] scratch_nxt;
    always_comb begin
        pin_func_nxt = pin_func_r;
        duty_one_nxt = duty_one_r;
        duty_two_nxt = duty_two_r;
        freq_nxt = freq_r;
        scratch_nxt = scratch_r;
        if (soft_reset_req) begin
            pin_func_nxt = `GPC_RST_VAL;
            duty_one_nxt = `GPC_RST_VAL;
            duty_two_nxt = `GPC_RST_VAL;
            freq_nxt = `GPC_RST_VAL;
        end else if (wr_en) begin
            if (hit_pin) begin
                pin_func_nxt = pwdata[7:0];
            end
            if (hit_d1) begin
                duty_one_nxt = pwdata[7:0];
            end
            if (hit_d2) begin
                duty_two_nxt = pwdata[7:0];
            end
            if (hit_frq) begin
                freq_nxt = pwdata[7:0] & `GPC_FREQ_MASK;
            end
        end
        // scratch survives soft reset, only software writes it
        if (wr_en && hit_scr && normal_mode) begin
            scratch_nxt = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func_r <= `GPC_RST_VAL;
            duty_one_r <= `GPC_RST_VAL;
            duty_two_r <= `GPC_RST_VAL;
            freq_r <= `GPC_RST_VAL;
            scratch_r <= `GPC_RST_VAL;
        end else begin
            pin_func_r <= pin_func_nxt;
            duty_one_r <= duty_one_nxt;
            duty_two_r <= duty_two_nxt;
            freq_r <= freq_nxt;
            scratch_r <= scratch_nxt;
        end
    end

    // =====================================================
    // read data, captured in the setup cycle
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (setup_ph) begin
            rdata_nxt = 32'h0000_0000;
            if (hit_pin) begin
                rdata_nxt[7:0] = pin_func_r;
            end
            if (hit_d1) begin
                rdata_nxt[7:0] = duty_one_r;
            end
            if (hit_d2) begin
                rdata_nxt[7:0] = duty_two_r;
            end
            if (hit_frq) begin
                rdata_nxt[7:0] = freq_r & `GPC_FREQ_MASK;
            end
            if (hit_scr && normal_mode) begin
                rdata_nxt[7:0] = scratch_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign prdata = rdata_r;

    // =====================================================
    // pwm generators
    gpc_pwm_gen u_pwm_one (
        .clk(pclk),
        .rst_n(presetn),
        .duty(duty_one_r),
        .fast(freq_r[`GPC_FREQ1_BIT]),
        .pwm_out(pwm_first_out)
    );

    gpc_pwm_gen u_pwm_two (
        .clk(pclk),
        .rst_n(presetn),
        .duty(duty_two_r),
        .fast(freq_r[`GPC_FREQ2_BIT]),
        .pwm_out(pwm_second_out)
    );

    // =====================================================
    // wake filters
    gpc_pin_mode_t mode_one;
    gpc_pin_mode_t mode_two;
    logic wake_one;
    logic wake_two;
    assign mode_one = pin_mode(pin_func_r[`GPC_P1_MSB:`GPC_P1_LSB]);
    assign mode_two = pin_mode(pin_func_r[`GPC_P2_MSB:`GPC_P2_LSB]);
    gpc_wake_filt u_wake_one (
        .clk(pclk),
        .rst_n(presetn),
        .en(mode_one == GPC_MODE_WAKE),
        .pin_in(pin_one_in),
        .level(wake_one)
    );

    gpc_wake_filt u_wake_two (
        .clk(pclk),
        .rst_n(presetn),
        .en(mode_two == GPC_MODE_WAKE),
        .pin_in(pin_two_in),
        .level(wake_two)
    );

    // =====================================================
    // pin and switch outputs
    gpc_pin_ctrl_t p1_r;
    gpc_pin_ctrl_t p1_nxt;
    gpc_pin_ctrl_t p2_r;
    gpc_pin_ctrl_t p2_nxt;
    logic [7:0] fpm_r;
    logic [7:0] fpm_nxt;
    logic [3:0] hsc_r;
    logic [3:0] hsc_nxt;
    logic [3:0] hsl_r;
    logic [3:0] hsl_nxt;
    always_comb begin
        p1_nxt = pin_ctrl(mode_one, wake_one);
        p2_nxt = pin_ctrl(mode_two, wake_two);
        unique case (pin_func_r[`GPC_FPD_MSB:`GPC_FPD_LSB])
            2'b00: fpm_nxt = `GPC_FPD_20;
            2'b01: fpm_nxt = `GPC_FPD_10;
            2'b10: fpm_nxt = `GPC_FPD_5;
            2'b11: fpm_nxt = `GPC_FPD_2P5;
        endcase
        for (int i = 0; i < 4; i++) begin
            hsc_nxt[i] = (hs_sel[i] == `GPC_HS_PWM1) || (hs_sel[i] == `GPC_HS_PWM2);
            hsl_nxt[i] = ((hs_sel[i] == `GPC_HS_PWM1) && pwm_first_out)
                || ((hs_sel[i] == `GPC_HS_PWM2) && pwm_second_out);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_r <= '0;
            p2_r <= '0;
            fpm_r <= `GPC_FPD_20;
            hsc_r <= 4'h0;
            hsl_r <= 4'h0;
        end else begin
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            fpm_r <= fpm_nxt;
            hsc_r <= hsc_nxt;
            hsl_r <= hsl_nxt;
        end
    end

    assign pin_one_ctrl = p1_r;
    assign pin_two_ctrl = p2_r;
    assign fail_pulse_duty = pin_func_r[`GPC_FPD_MSB:`GPC_FPD_LSB];
    assign fail_duty_permille = fpm_r;
    assign hs_pwm_ctrl = hsc_r;
    assign hs_pwm_level = hsl_r;
endmodule : gpc_top
`default_nettype wire

/* sim/gpc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// switches and pins
module gpc_far_model (
    input wire logic wake_req,
    input wire logic [3:0] hs_pwm_ctrl,
    input wire logic [3:0] hs_pwm_level,
    output logic pin_one_in,
    output logic pin_two_in,
    output var gpc_pkg::gpc_hs_sel_t hs_sel,
    output logic [3:0] switch_on
);
    import gpc_pkg::*;
    // switch 0 on first generator, 1 on second, 2 off, 3 other code
    // selectors stand for software routing; no timer codes are chosen here
    assign hs_sel = {3'h7, 3'h0, 3'h5, 3'h4};
    assign switch_on = hs_pwm_ctrl & hs_pwm_level;
    assign pin_one_in = wake_req;
    assign pin_two_in = wake_req;
endmodule : gpc_far_model
`default_nettype wire

/* sim/gpc_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module gpc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic soft_reset_req,
    input wire logic normal_mode,
    input wire gpc_pkg::gpc_hs_sel_t hs_sel,
    input wire gpc_pkg::gpc_pin_ctrl_t pin_one_ctrl,
    input wire gpc_pkg::gpc_pin_ctrl_t pin_two_ctrl,
    input wire logic [1:0] fail_pulse_duty,
    input wire logic [7:0] fail_duty_permille,
    input wire logic pwm_first_out,
    input wire logic pwm_second_out,
    input wire logic [3:0] hs_pwm_ctrl,
    input wire logic [3:0] hs_pwm_level
);
    import gpc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    duty_decode_a: assert property (fail_duty_permille == (8'hC8 >> $past(fail_pulse_duty)))
        else $error("fail duty decode wrong");
    pin_onehot_a: assert property ($onehot0({pin_one_ctrl[4:3], pin_one_ctrl[1:0]})
        && $onehot0({pin_two_ctrl[4:3], pin_two_ctrl[1:0]})) else $error("pin mode overlap");
    wake_gate_a: assert property (!pin_one_ctrl.wake_en |-> !pin_one_ctrl.wake_level)
        else $error("wake level without wake mode");
    freq_rsvd_a: assert property (psel && penable && !pwrite && paddr == 8'h70
        |-> (prdata & 32'hFFFFFFFA) == 32'h0) else $error("frequency spare bits set");
    scratch_lock_a: assert property (psel && penable && !pwrite && paddr == 8'h78
        && !normal_mode |-> prdata == 32'h0) else $error("scratch read outside normal");
    soft_clear_a: assert property (soft_reset_req |=> fail_pulse_duty == 2'h0)
        else $error("soft reset kept pin field");
    for (genvar i = 0; i < 4; i++) begin : g_sw
        hs_ctrl_a: assert property ($past(presetn) |-> hs_pwm_ctrl[i] ==
            ($past(hs_sel[i]) inside {3'h4, 3'h5})) else $error("switch select wrong");
        hs_level_a: assert property ($past(presetn) && $past(hs_sel[i]) inside {3'h4, 3'h5}
            |-> hs_pwm_level[i] == ($past(hs_sel[i][0]) ? $past(pwm_second_out)
            : $past(pwm_first_out))) else $error("switch level wrong");
    end
endmodule : gpc_props
bind gpc_top gpc_props gpc_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .soft_reset_req(soft_reset_req), .normal_mode(normal_mode), .hs_sel(hs_sel),
    .pin_one_ctrl(pin_one_ctrl), .pin_two_ctrl(pin_two_ctrl),
    .fail_pulse_duty(fail_pulse_duty), .fail_duty_permille(fail_duty_permille),
    .pwm_first_out(pwm_first_out), .pwm_second_out(pwm_second_out),
    .hs_pwm_ctrl(hs_pwm_ctrl), .hs_pwm_level(hs_pwm_level));
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module tb_top;
    import gpc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, soft_reset_req, normal_mode, wake_req;
    logic pready, pslverr, pin_one_in, pin_two_in, pwm_first_out, pwm_second_out, er_q;
    logic [7:0] paddr, fail_duty_permille;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] pstrb, hs_pwm_ctrl, hs_pwm_level, switch_on;
    logic [1:0] fail_pulse_duty;
    gpc_hs_sel_t hs_sel;
    gpc_pin_ctrl_t pin_one_ctrl, pin_two_ctrl;
    int num_errors, cmp_count, n;
    time rel;
    logic [7:0] reg_addr [5];
    gpc_top gpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .soft_reset_req(soft_reset_req),
        .normal_mode(normal_mode), .pin_one_in(pin_one_in), .pin_two_in(pin_two_in),
        .hs_sel(hs_sel), .pin_one_ctrl(pin_one_ctrl), .pin_two_ctrl(pin_two_ctrl),
        .fail_pulse_duty(fail_pulse_duty), .fail_duty_permille(fail_duty_permille),
        .pwm_first_out(pwm_first_out), .pwm_second_out(pwm_second_out),
        .hs_pwm_ctrl(hs_pwm_ctrl), .hs_pwm_level(hs_pwm_level));
    gpc_far_model gpc_far_model_i (.wake_req(wake_req), .hs_pwm_ctrl(hs_pwm_ctrl),
        .hs_pwm_level(hs_pwm_level), .pin_one_in(pin_one_in), .pin_two_in(pin_two_in),
        .hs_sel(hs_sel), .switch_on(switch_on));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task results();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            num_errors++;
            results();
        end
        rd_q = prdata;
        er_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        xfer(1'b0, a, 32'h0);
        chk(rd_q, exp);
        chk(32'(er_q), 32'(err));
    endtask : rd
    task wait_lvl(input int w, input logic v, input int lim);
        n = 0;
        while ((w == 0 ? pwm_second_out : w == 1 ? pwm_first_out : pin_one_ctrl.wake_level)
            !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n == lim) begin
            num_errors++;
            results();
        end
    endtask : wait_lvl
    function automatic logic [31:0] exp_ctrl(input int c);
        return 32'({c < 4, c == 5, 1'b0, c == 6, c == 7});
    endfunction : exp_ctrl
    initial begin
        {presetn, psel, penable, pwrite, soft_reset_req, wake_req} = 6'h00;
        {paddr, pwdata, pstrb, normal_mode} = {8'h00, 32'h0, 4'hF, 1'b1};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_addr = '{8'h5C, 8'h60, 8'h64, 8'h70, 8'h78};
        foreach (reg_addr[i]) begin
            rd(reg_addr[i], 32'h0, 1'b0);
        end
        $display("test reset values done");
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, 8'h5C, 32'({c[1:0], c[2:0], c[2:0]}));
            repeat (2) @(posedge pclk);
            chk(32'(pin_one_ctrl), exp_ctrl(c));
            chk(32'(pin_two_ctrl), exp_ctrl(c));
            chk(32'(fail_duty_permille), 32'(8'hC8 >> c[1:0]));
            chk(32'(fail_pulse_duty), 32'(c[1:0]));
        end
        $display("test pin decode done");
        xfer(1'b1, 8'h70, 32'hFFFFFFFF);
        rd(8'h70, 32'h5, 1'b0);
        pstrb <= 4'h0;
        xfer(1'b1, 8'h60, 32'h55);
        pstrb <= 4'hF;
        rd(8'h60, 32'h0, 1'b0);
        xfer(1'b1, 8'h78, 32'hA5);
        rd(8'h78, 32'hA5, 1'b0);
        normal_mode <= 1'b0;
        xfer(1'b1, 8'h78, 32'h3C);
        rd(8'h78, 32'h0, 1'b0);
        normal_mode <= 1'b1;
        rd(8'h78, 32'hA5, 1'b0);
        rd(8'h7C, 32'h0, 1'b1);
        rd(8'h5D, 32'h0, 1'b1);
        xfer(1'b1, 8'h5C, 32'hFF);
        xfer(1'b1, 8'h64, 32'h77);
        soft_reset_req <= 1'b1;
        @(posedge pclk);
        soft_reset_req <= 1'b0;
        rd(8'h5C, 32'h0, 1'b0);
        rd(8'h64, 32'h0, 1'b0);
        rd(8'h70, 32'h0, 1'b0);
        rd(8'h78, 32'hA5, 1'b0);
        $display("test registers done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rel = $time;
        @(posedge pclk);
        rd(8'h78, 32'h0, 1'b0);
        xfer(1'b1, 8'h70, 32'h1);
        xfer(1'b1, 8'h60, 32'h3);
        xfer(1'b1, 8'h64, 32'h1);
        chk(32'(hs_pwm_ctrl), 32'h3);
        chk(32'(pwm_first_out), 32'h1);
        wait_lvl(0, 1'b1, 3000);
        wait_lvl(0, 1'b0, 3000);
        chk(32'((($time - rel) / 20) inside {[975:990]}), 32'h1);
        wait_lvl(1, 1'b0, 3000);
        chk(32'((($time - rel) / 20) inside {[1465:1480]}), 32'h1);
        xfer(1'b1, 8'h60, 32'hFF);
        xfer(1'b1, 8'h64, 32'h0);
        repeat (600) @(posedge pclk);
        chk(32'({pwm_first_out, pwm_second_out}), 32'h2);
        chk(32'(switch_on), 32'h1);
        $display("test pwm done");
        xfer(1'b1, 8'h5C, 32'h2D);
        wake_req <= 1'b1;
        repeat (400) @(posedge pclk);
        wake_req <= 1'b0;
        repeat (10) @(posedge pclk);
        wake_req <= 1'b1;
        repeat (700) @(posedge pclk);
        chk(32'(pin_one_ctrl.wake_level), 32'h0);
        wait_lvl(2, 1'b1, 200);
        chk(32'(n inside {[95:115]}), 32'h1);
        chk(32'(pin_two_ctrl.wake_level), 32'h1);
        $display("test wake filter done");
        results();
    end
endmodule : tb_top
`default_nettype wire
